//--- src/lac_capture.sv
`timescale 1ns/1ps
`default_nettype none
module lac_capture import lac_pkg::*; #(
  parameter int MW = 40,
  parameter int MDEPTH = 1024,
  parameter int TW = 40,
  parameter int NT = 3,
  parameter bit REUSE_MON = 1,
  parameter int SW = 20,
  parameter int IPIPE = 3,
  parameter int OPIPE = 0,
  parameter int ARM_DELAY = 1,
  parameter bit EDGE_EN = 1,
  parameter bit BOOT_ARM = 0,
  parameter logic [1:0] BOOT_STAGES = 2'h1,
  parameter logic [8*TW-1:0] BOOT_PAT1 = {TW{8'h58}},
  parameter logic [8*TW-1:0] BOOT_PAT2 = {TW{8'h58}},
  parameter logic [8*TW-1:0] BOOT_PAT3 = {TW{8'h58}},
  parameter bit BOOT_AND1 = 1,
  parameter bit BOOT_AND2 = 1,
  parameter bit BOOT_AND3 = 1,
  parameter logic [1:0] BOOT_PRE = 2'h1,
  localparam int SWP = (SW < 1) ? 1 : SW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [LAC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [LAC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [MW-1:0] mon_in,
  input wire logic [TW-1:0] trig_in,
  output logic [SWP-1:0] stim_out,
  output logic stim_valid,
  output logic armed,
  output logic trig_pulse
);

  // depth rounds up to a power of two so the write pointer wraps freely
  localparam int AW = $clog2(MDEPTH);
  localparam int DR = 1 << AW;
  localparam int NW = (MW + 31) / 32;
  localparam int INIT_CYC = (MDEPTH <= LAC_INIT_DEPTH_LIM) ? LAC_INIT_SHORT : LAC_INIT_LONG;
  localparam int AD = (ARM_DELAY < 1) ? 1 : ARM_DELAY;
  // boot arming runs its arm delay inside init so the first user cycle gets stored
  localparam int INIT_END = (BOOT_ARM && INIT_CYC > AD) ? INIT_CYC - 1 - AD : INIT_CYC - 1;
  localparam int TCH = LAC_TRIG_EXTRA - 2;

  // ==========================================================
  // boot pattern decode
  function automatic lac_stage_t dec_pat(input logic [8*TW-1:0] s);
    lac_stage_t r;
    logic [7:0] c;
    r = '0;
    for (int i = 0; i < TW; i++) begin
      c = s[8*i +: 8];
      r.care[i] = (c == LAC_CH_0) || (c == LAC_CH_1) || (c == LAC_CH_R) || (c == LAC_CH_F);
      r.val[i] = (c == LAC_CH_1) || (c == LAC_CH_R);
      r.edg[i] = (c == LAC_CH_R) || (c == LAC_CH_F);
    end
    return r;
  endfunction

  lac_state_t state_reg;
  logic [2:0] init_cnt_reg;
  logic init_end;
  assign init_end = (state_reg == ST_INIT) && (init_cnt_reg == 3'(INIT_END));

  // ==========================================================
  // input pipeline: monitor and trigger delayed alike
  logic [MW+TW-1:0] ip_vec;
  generate
    if (IPIPE == 0) begin : g_nip
      assign ip_vec = {trig_in, mon_in};
    end else begin : g_ip
      logic [MW+TW-1:0] st [IPIPE];
      always_ff @(posedge aclk) begin
        st[0] <= {trig_in, mon_in};
        for (int i = 1; i < IPIPE; i++) begin
          st[i] <= st[i-1];
        end
      end
      assign ip_vec = st[IPIPE-1];
    end
  endgenerate

  logic [MW-1:0] mon_p;
  logic [TW-1:0] trig_p;
  logic [TW-1:0] trig_prev;
  assign mon_p = ip_vec[MW-1:0];
  assign trig_p = REUSE_MON ? mon_p[TW-1:0] : ip_vec[MW+TW-1:MW];

  always_ff @(posedge aclk) begin
    trig_prev <= trig_p;
  end

  // ==========================================================
  // configuration
  lac_stage_t pat_reg [LAC_PAT_SLOTS];
  logic [2:0] and_reg;
  logic [1:0] nst_reg;
  logic [1:0] pre_reg;
  logic [4:0] psel_reg;
  logic [3:0] ssel_reg;
  logic [31:0] rsel_reg;
  logic [LAC_STIM_MAX-1:0] stim_sh_reg;

  // ==========================================================
  // trigger match per stage
  logic [LAC_PAT_SLOTS-1:0] hit;
  genvar gs;
  generate
    for (gs = 0; gs < LAC_PAT_SLOTS; gs++) begin : g_stage
      if (gs < NT) begin : g_on
        logic [TW-1:0] lvl, edg_m, bm, care;
        assign care = pat_reg[gs].care[TW-1:0];
        assign lvl = pat_reg[gs].val[TW-1:0] ~^ trig_p;
        if (EDGE_EN) begin : g_edge
          assign edg_m = pat_reg[gs].val[TW-1:0] & trig_p & ~trig_prev
                       | ~pat_reg[gs].val[TW-1:0] & ~trig_p & trig_prev;
          assign bm = (pat_reg[gs].edg[TW-1:0] & edg_m) | (~pat_reg[gs].edg[TW-1:0] & lvl);
        end else begin : g_lvl
          assign edg_m = '0;
          assign bm = lvl;
        end
        // all-ignored under OR never fires, hence AND for that case
        assign hit[gs] = and_reg[gs] ? &(bm | ~care) : |(bm & care);
      end else begin : g_off
        assign hit[gs] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // register bus
  logic aw_held, w_held, rd_pend;
  logic [7:0] wa_reg, ra_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic do_wr, ar_take, aw_held_next, w_held_next;
  logic arm_cmd, abort_cmd;
  logic [31:0] rd_val;
  logic rd_ok;

  assign do_wr = aw_held & w_held & ~bvalid;
  assign ar_take = arvalid & arready;
  assign aw_held_next = (aw_held & ~do_wr) | (awvalid & awready);
  assign w_held_next = (w_held & ~do_wr) | (wvalid & wready);
  // partial strobes are ignored: a write takes effect only with all four strobes set
  assign arm_cmd = do_wr && (wa_reg == LAC_CTRL_OFS) && (ws_reg == 4'hf)
                   && wd_reg[LAC_CTRL_ARM_BIT];
  assign abort_cmd = do_wr && (wa_reg == LAC_CTRL_OFS) && (ws_reg == 4'hf)
                     && wd_reg[LAC_CTRL_ABORT_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= LAC_RESP_OKAY;
      wa_reg <= 8'h00;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
    end else begin
      aw_held <= aw_held_next;
      w_held <= w_held_next;
      awready <= ~aw_held_next;
      wready <= ~w_held_next;
      if (awvalid && awready) begin
        wa_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wd_reg <= wdata;
        ws_reg <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= (wa_reg <= LAC_RDATA_OFS && wa_reg[1:0] == 2'h0) ? LAC_RESP_OKAY
                 : LAC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= LAC_RESP_OKAY;
      ra_reg <= 8'h00;
    end else begin
      rd_pend <= ar_take;
      arready <= ~(ar_take | rd_pend | (rvalid & ~rready));
      if (ar_take) begin
        ra_reg <= araddr;
      end
      if (rd_pend) begin
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? LAC_RESP_OKAY : LAC_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pattern write helper
  logic [1:0] ps, pf;
  logic [LAC_TW_MAX-1:0] pf_cur, pf_new;
  assign ps = psel_reg[1:0];
  assign pf = psel_reg[3:2];
  always_comb begin
    if (pf == LAC_FLD_CARE) begin
      pf_cur = pat_reg[ps].care;
    end else if (pf == LAC_FLD_VAL) begin
      pf_cur = pat_reg[ps].val;
    end else begin
      pf_cur = pat_reg[ps].edg;
    end
    pf_new = psel_reg[4] ? {wd_reg[LAC_HI_W-1:0], pf_cur[31:0]}
                         : {pf_cur[LAC_TW_MAX-1:32], wd_reg};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LAC_PAT_SLOTS; i++) begin
        pat_reg[i] <= '0;
      end
      and_reg <= LAC_AND_RST;
      nst_reg <= LAC_NST_RST;
      pre_reg <= LAC_PRE_RST;
      psel_reg <= 5'h0;
      ssel_reg <= 4'h0;
      rsel_reg <= 32'h0;
      stim_sh_reg <= '0;
    end else if (init_end && BOOT_ARM) begin
      pat_reg[0] <= dec_pat(BOOT_PAT1);
      pat_reg[1] <= dec_pat(BOOT_PAT2);
      pat_reg[2] <= dec_pat(BOOT_PAT3);
      and_reg <= {BOOT_AND3, BOOT_AND2, BOOT_AND1};
      nst_reg <= BOOT_STAGES;
      pre_reg <= BOOT_PRE;
    end else if (do_wr && ws_reg == 4'hf) begin
      if (wa_reg == LAC_CTRL_OFS) begin
        pre_reg <= wd_reg[LAC_CTRL_PRE_LSB +: 2];
        nst_reg <= wd_reg[LAC_CTRL_NST_LSB +: 2];
        and_reg <= wd_reg[LAC_CTRL_AND_LSB +: 3];
      end else if (wa_reg == LAC_PSEL_OFS) begin
        psel_reg <= wd_reg[4:0];
      end else if (wa_reg == LAC_PDATA_OFS) begin
        if (pf == LAC_FLD_CARE) begin
          pat_reg[ps].care <= pf_new;
        end else if (pf == LAC_FLD_VAL) begin
          pat_reg[ps].val <= pf_new;
        end else if (pf == LAC_FLD_EDGE) begin
          pat_reg[ps].edg <= pf_new;
        end
      end else if (wa_reg == LAC_SSEL_OFS) begin
        ssel_reg <= wd_reg[3:0];
      end else if (wa_reg == LAC_SDATA_OFS) begin
        stim_sh_reg[ssel_reg*32 +: 32] <= wd_reg;
      end else if (wa_reg == LAC_RSEL_OFS) begin
        rsel_reg <= wd_reg;
      end
    end
  end

  // ==========================================================
  // sequencer
  logic [1:0] stg_reg;
  logic [$clog2(AD+1)-1:0] dcnt_reg;
  logic sv_int, arm_int, trig_evt;
  logic [SWP-1:0] stim_int;
  logic [AW:0] filled_reg, post_left_reg, pre_n, pre_have;
  logic [AW-1:0] wr_ptr_reg, start_reg, tpos_reg;
  logic fin_hit;

  assign pre_n = (AW+1)'(DR / 4) * (AW+1)'(pre_reg);
  assign pre_have = (filled_reg < pre_n) ? filled_reg : pre_n;
  assign fin_hit = (state_reg == ST_ARMED) && hit[stg_reg] && (stg_reg == nst_reg - 2'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_INIT;
      init_cnt_reg <= 3'h0;
      stg_reg <= 2'h0;
      dcnt_reg <= '0;
      sv_int <= 1'b0;
      arm_int <= 1'b0;
      stim_int <= '0;
      filled_reg <= '0;
      post_left_reg <= '0;
      start_reg <= '0;
      tpos_reg <= '0;
      trig_evt <= 1'b0;
    end else begin
      trig_evt <= fin_hit;
      case (state_reg)
        ST_INIT: begin
          init_cnt_reg <= init_cnt_reg + 3'h1;
          if (init_end) begin
            state_reg <= BOOT_ARM ? ST_ARMWAIT : ST_IDLE;
            sv_int <= BOOT_ARM;
            dcnt_reg <= '0;
          end
        end
        ST_IDLE, ST_DONE: begin
          if (arm_cmd) begin
            state_reg <= ST_ARMWAIT;
            sv_int <= 1'b1;
            stim_int <= stim_sh_reg[SWP-1:0];
            dcnt_reg <= '0;
          end
        end
        ST_ARMWAIT: begin
          if (dcnt_reg == ($clog2(AD+1))'(AD - 1)) begin
            state_reg <= ST_ARMED;
            arm_int <= 1'b1;
            stg_reg <= 2'h0;
            filled_reg <= '0;
          end else begin
            dcnt_reg <= dcnt_reg + 1'b1;
          end
        end
        ST_ARMED: begin
          if (filled_reg != (AW+1)'(DR)) begin
            filled_reg <= filled_reg + 1'b1;
          end
          if (fin_hit) begin
            state_reg <= ST_POST;
            start_reg <= wr_ptr_reg - pre_have[AW-1:0];
            tpos_reg <= pre_have[AW-1:0];
            post_left_reg <= (AW+1)'(DR) - pre_have - 1'b1;
          end else if (hit[stg_reg]) begin
            stg_reg <= stg_reg + 2'h1;
          end
        end
        ST_POST: begin
          post_left_reg <= post_left_reg - 1'b1;
          if (post_left_reg == (AW+1)'(1)) begin
            state_reg <= ST_DONE;
            sv_int <= 1'b0;
            arm_int <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (abort_cmd && state_reg != ST_INIT) begin
        state_reg <= ST_IDLE;
        sv_int <= 1'b0;
        arm_int <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sample store
  logic [MW-1:0] mem [DR];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
    end else if (state_reg == ST_ARMED || state_reg == ST_POST) begin
      mem[wr_ptr_reg] <= mon_p;
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // ==========================================================
  // read mux
  logic [AW-1:0] rd_row;
  logic [NW*32-1:0] row_pad;
  logic [6:0] rd_word;
  assign rd_row = start_reg + rsel_reg[AW-1:0];
  assign rd_word = rsel_reg[LAC_RSEL_WORD_LSB +: 7];
  assign row_pad = (NW*32)'(mem[rd_row]);

  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    if (ra_reg == LAC_CTRL_OFS) begin
      rd_val = 32'({and_reg, nst_reg, pre_reg, 2'h0});
    end else if (ra_reg == LAC_STATUS_OFS) begin
      rd_val = 32'({stg_reg, sv_int, arm_int, 3'(state_reg)});
    end else if (ra_reg == LAC_START_OFS) begin
      rd_val = 32'(start_reg);
    end else if (ra_reg == LAC_TPOS_OFS) begin
      rd_val = 32'(tpos_reg);
    end else if (ra_reg == LAC_PSEL_OFS) begin
      rd_val = 32'(psel_reg);
    end else if (ra_reg == LAC_PDATA_OFS) begin
      rd_val = psel_reg[4] ? 32'(pf_cur[LAC_TW_MAX-1:32]) : pf_cur[31:0];
    end else if (ra_reg == LAC_SSEL_OFS) begin
      rd_val = 32'(ssel_reg);
    end else if (ra_reg == LAC_SDATA_OFS) begin
      rd_val = stim_sh_reg[ssel_reg*32 +: 32];
    end else if (ra_reg == LAC_RSEL_OFS) begin
      rd_val = rsel_reg;
    end else if (ra_reg == LAC_RDATA_OFS) begin
      rd_val = (32'(rd_word) < NW) ? row_pad[rd_word*32 +: 32] : 32'h0;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ==========================================================
  // trigger pulse: registered hit plus chain, no output stages
  logic [TCH-1:0] tchain;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tchain <= '0;
      trig_pulse <= 1'b0;
    end else begin
      tchain <= {tchain[TCH-2:0], trig_evt};
      trig_pulse <= tchain[TCH-1];
    end
  end

  // ==========================================================
  // output stages
  generate
    if (OPIPE == 0) begin : g_nop
      assign stim_out = stim_int;
      assign stim_valid = sv_int;
      assign armed = arm_int;
    end else begin : g_op
      logic [SWP+1:0] op [OPIPE];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          for (int i = 0; i < OPIPE; i++) begin
            op[i] <= '0;
          end
        end else begin
          op[0] <= {stim_int, sv_int, arm_int};
          for (int i = 1; i < OPIPE; i++) begin
            op[i] <= op[i-1];
          end
        end
      end
      assign {stim_out, stim_valid, armed} = op[OPIPE-1];
    end
  endgenerate

endmodule
`default_nettype wire

//--- src/lac_pkg.sv
package lac_pkg;

  localparam int LAC_ADDR_W = 8;
  localparam int LAC_TW_MAX = 40;
  localparam int LAC_HI_W = LAC_TW_MAX - 32;
  localparam int LAC_PAT_SLOTS = 4;
  localparam int LAC_STIM_MAX = 512;

  // register offsets
  localparam logic [7:0] LAC_CTRL_OFS = 8'h00;
  localparam logic [7:0] LAC_STATUS_OFS = 8'h04;
  localparam logic [7:0] LAC_START_OFS = 8'h08;
  localparam logic [7:0] LAC_TPOS_OFS = 8'h0c;
  localparam logic [7:0] LAC_PSEL_OFS = 8'h10;
  localparam logic [7:0] LAC_PDATA_OFS = 8'h14;
  localparam logic [7:0] LAC_SSEL_OFS = 8'h18;
  localparam logic [7:0] LAC_SDATA_OFS = 8'h1c;
  localparam logic [7:0] LAC_RSEL_OFS = 8'h20;
  localparam logic [7:0] LAC_RDATA_OFS = 8'h24;

  // control field positions
  localparam int LAC_CTRL_ARM_BIT = 0;
  localparam int LAC_CTRL_ABORT_BIT = 1;
  localparam int LAC_CTRL_PRE_LSB = 2;
  localparam int LAC_CTRL_NST_LSB = 4;
  localparam int LAC_CTRL_AND_LSB = 6;
  localparam int LAC_RSEL_WORD_LSB = 16;

  // reset values
  localparam logic [1:0] LAC_PRE_RST = 2'h0;
  localparam logic [1:0] LAC_NST_RST = 2'h1;
  localparam logic [2:0] LAC_AND_RST = 3'h7;

  // pattern field selectors
  localparam logic [1:0] LAC_FLD_CARE = 2'h0;
  localparam logic [1:0] LAC_FLD_VAL = 2'h1;
  localparam logic [1:0] LAC_FLD_EDGE = 2'h2;

  // boot pattern characters
  localparam logic [7:0] LAC_CH_0 = 8'h30;
  localparam logic [7:0] LAC_CH_1 = 8'h31;
  localparam logic [7:0] LAC_CH_R = 8'h52;
  localparam logic [7:0] LAC_CH_F = 8'h46;
  localparam logic [7:0] LAC_CH_X = 8'h58;

  // timing
  localparam int LAC_INIT_DEPTH_LIM = 1024;
  localparam int LAC_INIT_SHORT = 3;
  localparam int LAC_INIT_LONG = 6;
  localparam int LAC_TRIG_EXTRA = 5;

  localparam logic [1:0] LAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LAC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [LAC_TW_MAX-1:0] care;
    logic [LAC_TW_MAX-1:0] val;
    logic [LAC_TW_MAX-1:0] edg;
  } lac_stage_t;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_ARMWAIT, ST_ARMED, ST_POST, ST_DONE
  } lac_state_t;

endpackage

//--- test/lac_capture_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// capture checker
module lac_capture_asserts import lac_pkg::*; #(
  parameter int SW = 20,
  localparam int SWP = (SW < 1) ? 1 : SW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [SWP-1:0] stim_out,
  input wire logic stim_valid,
  input wire logic armed,
  input wire logic trig_pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_armed_sv; armed |-> stim_valid; endproperty
  a_armed_sv: assert property (p_armed_sv) else $error("armed without stim_valid");
  property p_arm_delay; $rose(stim_valid) |-> !armed ##1 armed; endproperty
  a_arm_delay: assert property (p_arm_delay) else $error("armed delay wrong");
  property p_fall_both; $fell(armed) |-> $fell(stim_valid); endproperty
  a_fall_both: assert property (p_fall_both) else $error("armed fell alone");
  property p_pulse_once; trig_pulse |=> !trig_pulse; endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("trigger pulse too long");
  property p_pulse_cap; trig_pulse |-> armed && stim_valid; endproperty
  a_pulse_cap: assert property (p_pulse_cap) else $error("pulse outside capture");
  property p_stim_hold; stim_valid && $past(stim_valid) |-> $stable(stim_out); endproperty
  a_stim_hold: assert property (p_stim_hold) else $error("stim_out moved");
  property p_bresp;
    awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late");
  property p_rgap; arvalid && arready |=> !rvalid ##1 rvalid; endproperty
  a_rgap: assert property (p_rgap) else $error("read answer timing");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_pulse: cover property (trig_pulse);
  c_done: cover property ($fell(stim_valid));
  c_read: cover property (rvalid && rready);
endmodule
bind lac_capture lac_capture_asserts #(.SW(SW)) u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rdata, .rvalid, .rready, .stim_out, .stim_valid, .armed, .trig_pulse);
`default_nettype wire

//--- test/lac_user_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// observed user logic
module lac_user_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [19:0] stim_out,
  input wire logic stim_valid,
  output logic [39:0] mon_in,
  output logic [39:0] trig_in
);
  // no chained access unit here, so no serial chain input to tie low
  logic [9:0] cyc_reg;
  logic sv_reg;
  // counting monitor makes each stored row identifiable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_in <= 40'h0;
    end else begin
      mon_in <= mon_in + 40'h1;
    end
  end
  // stimulus low bits give a delay, high bits a one-cycle pattern
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sv_reg <= 1'b0;
      cyc_reg <= 10'h0;
      trig_in <= 40'h0;
    end else begin
      sv_reg <= stim_valid;
      if (stim_valid && !sv_reg) begin
        cyc_reg <= 10'h1;
      end else if (cyc_reg != 10'h0) begin
        cyc_reg <= cyc_reg + 10'h1;
      end
      if (stim_valid && cyc_reg == stim_out[9:0]) begin
        trig_in <= {30'h0, stim_out[19:10]};
      end else begin
        trig_in <= 40'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/test_logic_analyzer_capture.sv
`timescale 1ns/1ps
`default_nettype none
module test_logic_analyzer_capture import lac_pkg::*;;
  localparam int IPIPE = 3;
  logic aclk, aresetn, tr_any;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, wr_resp;
  logic [39:0] mon_in, trig_in;
  logic [19:0] stim_out;
  logic stim_valid, armed, trig_pulse;
  int errors = 0;
  int num_checks = 0;
  lac_capture #(.MDEPTH(512), .REUSE_MON(1'b0), .IPIPE(IPIPE)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .mon_in, .trig_in, .stim_out, .stim_valid, .armed, .trig_pulse);
  lac_user_model u_user (.aclk, .aresetn, .stim_out, .stim_valid, .mon_in, .trig_in);
  always_comb tr_any = |trig_in;
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ==========
  // helpers
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (s !== v) begin
      errors++;
      $display("ERROR wait timeout expected %h seen %h", v, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      wr_resp = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      d = rdata;
      r = rresp;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic setp(input logic [1:0] s, input logic [31:0] c, v, e);
    wr(LAC_PSEL_OFS, {28'h0, LAC_FLD_CARE, s});
    wr(LAC_PDATA_OFS, c);
    wr(LAC_PSEL_OFS, {28'h0, LAC_FLD_VAL, s});
    wr(LAC_PDATA_OFS, v);
    wr(LAC_PSEL_OFS, {28'h0, LAC_FLD_EDGE, s});
    wr(LAC_PDATA_OFS, e);
  endtask
  // arm, wait for the partner event, then judge pulse timing and record
  task automatic run(input logic [31:0] ctl, input logic [19:0] st, input int ex, tp);
    logic [31:0] d;
    logic [1:0] r;
    logic [39:0] mt;
    wr(LAC_SSEL_OFS, 32'h0);
    wr(LAC_SDATA_OFS, {12'h0, st});
    wr(LAC_CTRL_OFS, ctl);
    wr(LAC_CTRL_OFS, ctl | 32'h1);
    wt(stim_valid, 1'b1, 20);
    chk("stim_out", st, stim_out);
    wt(tr_any, 1'b1, 1100);
    mt = mon_in;
    wt(trig_pulse, 1'b1, 20);
    chk("pulse delay", 40'(IPIPE + LAC_TRIG_EXTRA + ex), mon_in - mt);
    wt(stim_valid, 1'b0, 1100);
    chk("armed at done", 1'b0, armed);
    rd(LAC_TPOS_OFS, d, r);
    chk("tpos", 32'(tp), d);
    wr(LAC_RSEL_OFS, 32'(tp));
    rd(LAC_RDATA_OFS, d, r);
    chk("trigger row", mt[31:0] + 32'(ex), d);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    chk("stim_valid", 1'b0, stim_valid);
    chk("armed", 1'b0, armed);
    repeat (8) @(posedge aclk);
    rd(LAC_STATUS_OFS, d, r);
    chk("state", 3'h1, d[2:0]);
    rd(8'h28, d, r);
    chk("unmapped resp", LAC_RESP_SLVERR, r);
    wr(8'h28, 32'h0);
    chk("unmapped write resp", LAC_RESP_SLVERR, wr_resp);
    $display("reset test done");
  endtask
  task automatic t_level();
    logic [31:0] d;
    logic [1:0] r;
    setp(2'h0, 32'hf, 32'ha, 32'h0);
    run(32'h1d0, {10'h00a, 10'h014}, 0, 0);
    rd(LAC_CTRL_OFS, d, r);
    chk("ctrl", 32'h1d0, d);
    chk("write resp", LAC_RESP_OKAY, wr_resp);
    $display("level test done");
  endtask
  task automatic t_edge_seq();
    setp(2'h0, 32'h1, 32'h1, 32'h1);
    setp(2'h1, 32'h1, 32'h0, 32'h1);
    setp(2'h2, 32'h0, 32'h0, 32'h0);
    run(32'h1f8, {10'h001, 10'h190}, 2, 256);
    $display("edge sequence test done");
  endtask
  task automatic t_or_pre();
    setp(2'h0, 32'h3, 32'h3, 32'h0);
    for (int c = 0; c < 4; c++) begin
      run(32'h190 | (32'(c) << 2), {10'h002, 10'h190}, 0, 128 * c);
    end
    $display("pre-store test done");
  endtask
  task automatic t_abort();
    logic [31:0] d;
    logic [1:0] r;
    setp(2'h0, 32'h1, 32'h1, 32'h0);
    wr(LAC_CTRL_OFS, 32'h1d1);
    wt(armed, 1'b1, 10);
    chk("armed", 1'b1, armed);
    wr(LAC_CTRL_OFS, 32'h1d2);
    wt(stim_valid, 1'b0, 10);
    chk("armed after abort", 1'b0, armed);
    rd(LAC_STATUS_OFS, d, r);
    chk("state", 3'h1, d[2:0]);
    $display("abort test done");
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    end_of_test();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_level();
    t_edge_seq();
    t_or_pre();
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
